// ### hdl/ccsp_pkg.sv
// Purpose: constants and carriers for the can control/status partition
// Assumes: 32-bit axi4-lite register bus, one clock
// Notes: control byte in bits 7:0, status byte in bits 15:8
package ccsp_pkg;
   localparam int unsigned CCSP_AW = 4;
   localparam logic [CCSP_AW-1:0] CCSP_OFF_CTRL_STAT = 4'h0;
   localparam logic [CCSP_AW-1:0] CCSP_OFF_BIT_TIMING = 4'h4;
   localparam logic [CCSP_AW-1:0] CCSP_OFF_CTRL_ONLY = 4'h8;
   // control byte fields
   localparam int unsigned CCSP_B_INIT = 0;
   localparam int unsigned CCSP_B_IE = 1;
   localparam int unsigned CCSP_B_SIE = 2;
   localparam int unsigned CCSP_B_EIE = 3;
   localparam int unsigned CCSP_B_CCE = 6;
   localparam int unsigned CCSP_B_TST = 7;
   // status byte fields
   localparam int unsigned CCSP_B_LEC_LO = 8;
   localparam int unsigned CCSP_B_TRANSMIT_OK_FLAG = 11;
   localparam int unsigned CCSP_B_RECEIVE_OK_FLAG = 12;
   localparam int unsigned CCSP_B_ERROR_WARNING_STATUS = 14;
   localparam int unsigned CCSP_B_BUSOFF_STATUS = 15;
   localparam logic CCSP_RST_INIT = 1'h1;
   localparam logic [15:0] CCSP_RST_BIT_TIMING = 16'h0000;
   localparam int unsigned CCSP_WARN_LIMIT = 96;
   localparam logic [1:0] CCSP_RESP_OKAY = 2'h0;
   localparam logic [1:0] CCSP_RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      CCSP_LEC_NONE = 3'h0,
      CCSP_LEC_STUFF = 3'h1,
      CCSP_LEC_FORM = 3'h2,
      CCSP_LEC_ACK = 3'h3,
      CCSP_LEC_BIT1 = 3'h4,
      CCSP_LEC_BIT0 = 3'h5,
      CCSP_LEC_CRC = 3'h6,
      CCSP_LEC_UNUSED = 3'h7
   } ccsp_lec_e;
   // events from the protocol engine, same clock
   typedef struct packed {
      logic err_valid;
      ccsp_lec_e err_code;
      logic tx_ok;
      logic rx_ok;
      logic recessive_run11;
      logic busoff;
      logic [7:0] tx_err_cnt;
      logic [7:0] rx_err_cnt;
   } ccsp_evt_s;
   // control towards the protocol engine
   typedef struct packed {
      logic init;
      logic irq_en;
      logic test_mode_bit;
      logic [15:0] bit_timing;
   } ccsp_ctl_s;
endpackage

// ### hdl/ccsp_sticky_flag.sv
// Purpose: sticky status flag, hardware sets, software clears
// Assumes: set and clear are one-cycle pulses on aclk
// Notes: set beats a clear in the same cycle
`timescale 1ns/1ps
module ccsp_sticky_flag (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   typedef struct packed {
      logic flag;
   } ccsp_flag_s;
   ccsp_flag_s st_q;
   ccsp_flag_s st_d;
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.flag = 1'b0;
      end
      // no event is lost to a racing clear
      if (set) begin
         st_d.flag = 1'b1;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign q = st_q.flag;
endmodule // ccsp_sticky_flag

// ### hdl/ccsp_warn_cmp.sv
// Purpose: error counter against warning limit
// Assumes: counter from the error management logic, same clock
// Notes: purely combinational
`timescale 1ns/1ps
module ccsp_warn_cmp #(
   parameter int unsigned CNT_W = 8,
   parameter int unsigned LIMIT = 96
) (
   input wire logic [CNT_W-1:0] cnt,
   output logic at_limit
);
   // refused at elaboration: a limit the counter never reaches would hide every warning
   if (LIMIT >= (64'h1 << CNT_W)) begin : g_bad_limit
      $error("warning limit does not fit the counter");
   end
   assign at_limit = (cnt >= CNT_W'(LIMIT));
endmodule // ccsp_warn_cmp

// ### hdl/ccsp_ctrl_status.sv
// Purpose: can control register, status partition and bit timing gate
// Assumes: axi4-lite slave, protocol engine events on aclk
// Notes: read of offset 0x0 clears status change; 0x8 reads control only
// Behaviour
// - bit timing register writable only while config change enable is set
// - last error code holds type of most recent bus error, zero none
// - error-free transfer clears last error code to zero
// - code 7 never produced by hardware, software may write it
// - stuff error records code 1
// - form error records code 2
// - missing acknowledge on own frame records code 3
// - recessive sent but dominant seen records code 4
// - dominant sent but recessive seen records code 5
// - each eleven-recessive run during busoff recovery records code 5
// - crc mismatch records code 6
// - transmit-ok set after error-free acknowledged transmission
// - receive-ok set after successful reception
// - ok flags stay set until software clears them
// - error warning set while either error counter reaches 96
// - busoff status follows busoff state of error management
// - reading status partition clears pending status change interrupt
// - entering busoff sets init; recovery after software clears it
// - writing status partition never makes or clears an interrupt
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ccsp_ctrl_status (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ccsp_pkg::CCSP_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ccsp_pkg::CCSP_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ccsp_pkg::ccsp_evt_s evt,
   output ccsp_pkg::ccsp_ctl_s ctl,
   output logic status_change_pending
);
   import ccsp_pkg::*;

   typedef struct packed {
      logic aw_got;
      logic [CCSP_AW-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic init;
      logic ie;
      logic sie;
      logic eie;
      logic cce;
      logic tst;
      logic [15:0] bit_timing;
      ccsp_lec_e last_error_code;
      logic error_warning_status;
      logic busoff_status;
      logic pend;
   } ccsp_state_s;

   ccsp_state_s st_q;
   ccsp_state_s st_d;
   logic transmit_ok_flag;
   logic receive_ok_flag;
   logic tx_warn;
   logic rx_warn;
   logic wr_fire;
   logic rd_fire;
   logic wr_status;
   logic rd_status;
   logic lec_upd;
   logic [15:0] reg_word;

   ccsp_warn_cmp #(.CNT_W(8), .LIMIT(CCSP_WARN_LIMIT)) u_tx_warn (
      .cnt(evt.tx_err_cnt),
      .at_limit(tx_warn)
   );
   ccsp_warn_cmp #(.CNT_W(8), .LIMIT(CCSP_WARN_LIMIT)) u_rx_warn (
      .cnt(evt.rx_err_cnt),
      .at_limit(rx_warn)
   );

   assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   // only the lane holding the status byte touches status bits
   assign wr_status = wr_fire && (st_q.awaddr == CCSP_OFF_CTRL_STAT) && st_q.wstrb[1];
   assign rd_status = rd_fire && (s_axi_araddr == CCSP_OFF_CTRL_STAT);

   ccsp_sticky_flag u_transmit_ok_flag (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(evt.tx_ok),
      .clr(wr_status && !st_q.wdata[CCSP_B_TRANSMIT_OK_FLAG]),
      .q(transmit_ok_flag)
   );
   ccsp_sticky_flag u_receive_ok_flag (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(evt.rx_ok),
      .clr(wr_status && !st_q.wdata[CCSP_B_RECEIVE_OK_FLAG]),
      .q(receive_ok_flag)
   );

   // hardware never reports code 7, so a written 7 marks "no update yet"
   assign lec_upd = (evt.err_valid && evt.err_code != CCSP_LEC_UNUSED)
      || (evt.busoff && evt.recessive_run11) || evt.tx_ok || evt.rx_ok;

   always_comb begin
      reg_word = '0;
      reg_word[CCSP_B_INIT] = st_q.init;
      reg_word[CCSP_B_IE] = st_q.ie;
      reg_word[CCSP_B_SIE] = st_q.sie;
      reg_word[CCSP_B_EIE] = st_q.eie;
      reg_word[CCSP_B_CCE] = st_q.cce;
      reg_word[CCSP_B_TST] = st_q.tst;
      reg_word[CCSP_B_LEC_LO +: 3] = st_q.last_error_code;
      reg_word[CCSP_B_TRANSMIT_OK_FLAG] = transmit_ok_flag;
      reg_word[CCSP_B_RECEIVE_OK_FLAG] = receive_ok_flag;
      reg_word[CCSP_B_ERROR_WARNING_STATUS] = st_q.error_warning_status;
      reg_word[CCSP_B_BUSOFF_STATUS] = st_q.busoff_status;
   end

   always_comb begin
      st_d = st_q;
      // write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_d.aw_got = 1'b1;
         st_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_d.w_got = 1'b1;
         st_d.wdata = s_axi_wdata;
         st_d.wstrb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (wr_fire) begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = CCSP_RESP_OKAY;
         unique case (st_q.awaddr)
            CCSP_OFF_CTRL_STAT, CCSP_OFF_CTRL_ONLY: begin
               if (st_q.wstrb[0]) begin
                  st_d.init = st_q.wdata[CCSP_B_INIT];
                  st_d.ie = st_q.wdata[CCSP_B_IE];
                  st_d.sie = st_q.wdata[CCSP_B_SIE];
                  st_d.eie = st_q.wdata[CCSP_B_EIE];
                  st_d.cce = st_q.wdata[CCSP_B_CCE];
                  // stored as written; a set bit is software's fault
                  st_d.tst = st_q.wdata[CCSP_B_TST];
               end
               if (wr_status) begin
                  st_d.last_error_code = ccsp_lec_e'(st_q.wdata[CCSP_B_LEC_LO +: 3]);
               end
            end
            CCSP_OFF_BIT_TIMING: begin
               if (st_q.cce) begin
                  if (st_q.wstrb[0]) begin
                     st_d.bit_timing[7:0] = st_q.wdata[7:0];
                  end
                  if (st_q.wstrb[1]) begin
                     st_d.bit_timing[15:8] = st_q.wdata[15:8];
                  end
               end
            end
            default: begin
               st_d.bresp = CCSP_RESP_SLVERR;
            end
         endcase
      end
      if (rd_fire) begin
         st_d.rvalid = 1'b1;
         st_d.rresp = CCSP_RESP_OKAY;
         st_d.rdata = '0;
         unique case (s_axi_araddr)
            CCSP_OFF_CTRL_STAT: st_d.rdata[15:0] = reg_word;
            CCSP_OFF_CTRL_ONLY: st_d.rdata[7:0] = reg_word[7:0];
            CCSP_OFF_BIT_TIMING: begin
               if (st_q.cce) begin
                  st_d.rdata[15:0] = st_q.bit_timing;
               end
            end
            default: st_d.rresp = CCSP_RESP_SLVERR;
         endcase
      end
      // hardware updates of the error code win over a cpu write
      if (lec_upd) begin
         if (evt.err_valid && evt.err_code != CCSP_LEC_UNUSED) begin
            st_d.last_error_code = evt.err_code;
         end else if (evt.busoff && evt.recessive_run11) begin
            st_d.last_error_code = CCSP_LEC_BIT0;
         end else begin
            st_d.last_error_code = CCSP_LEC_NONE;
         end
      end
      st_d.error_warning_status = tx_warn || rx_warn;
      st_d.busoff_status = evt.busoff;
      if (evt.busoff && !st_q.busoff_status) begin
         st_d.init = 1'b1;
      end
      // only a read clears; the status write path never touches pend
      if (rd_status) begin
         st_d.pend = 1'b0;
      end
      if ((st_q.sie && (lec_upd || evt.tx_ok || evt.rx_ok))
         || (st_q.eie && (st_d.error_warning_status != st_q.error_warning_status || st_d.busoff_status != st_q.busoff_status))) begin
         st_d.pend = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.init <= CCSP_RST_INIT;
         st_q.bit_timing <= CCSP_RST_BIT_TIMING;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
   assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign ctl.init = st_q.init;
   assign ctl.irq_en = st_q.ie;
   assign ctl.test_mode_bit = st_q.tst;
   assign ctl.bit_timing = st_q.bit_timing;
   assign status_change_pending = st_q.pend;

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_BT_GATED: assert property (
      !st_q.cce |=> $stable(st_q.bit_timing))
      else $error("bit timing changed while config change disabled");
   AST_LEC_ERR: assert property (
      evt.err_valid && evt.err_code != CCSP_LEC_UNUSED |=> st_q.last_error_code == $past(evt.err_code))
      else $error("last error code not recorded");
   AST_LEC_OK: assert property (
      (evt.tx_ok || evt.rx_ok) && !evt.err_valid && !(evt.busoff && evt.recessive_run11)
      |=> st_q.last_error_code == CCSP_LEC_NONE)
      else $error("last error code not cleared on good transfer");
   AST_NO_SEVEN: assert property (
      evt.err_valid && evt.err_code == CCSP_LEC_UNUSED && !evt.tx_ok && !evt.rx_ok
      && !(evt.busoff && evt.recessive_run11) && !wr_status |=> $stable(st_q.last_error_code))
      else $error("hardware produced unused error code");
   AST_RUN11: assert property (
      evt.busoff && evt.recessive_run11 && !evt.err_valid |=> st_q.last_error_code == CCSP_LEC_BIT0)
      else $error("recovery progress code missing");
   AST_TRANSMIT_OK_FLAG: assert property (
      evt.tx_ok |=> transmit_ok_flag)
      else $error("transmit ok not set");
   AST_OK_HOLD: assert property (
      receive_ok_flag && !wr_status |=> receive_ok_flag)
      else $error("receive ok cleared by hardware");
   AST_ERROR_WARNING_STATUS: assert property (
      (evt.tx_err_cnt >= 8'(CCSP_WARN_LIMIT) || evt.rx_err_cnt >= 8'(CCSP_WARN_LIMIT))
      |=> st_q.error_warning_status)
      else $error("error warning missing");
   AST_BUSOFF_STATUS: assert property (
      evt.busoff |=> st_q.busoff_status ##1 (st_q.busoff_status == $past(evt.busoff)))
      else $error("busoff status does not follow");
   AST_RD_CLR: assert property (
      rd_status && !lec_upd && !st_q.eie |=> !status_change_pending ##0 s_axi_rvalid)
      else $error("status read did not clear pending");
   AST_WR_KEEP: assert property (
      status_change_pending && wr_status && !rd_status |=> status_change_pending)
      else $error("status write cleared pending");
   AST_INIT_BUSOFF_STATUS: assert property (
      evt.busoff && !st_q.busoff_status |=> st_q.init)
      else $error("init not set on busoff entry");

   COV_WRITE: cover property (wr_fire ##[1:4] s_axi_bvalid && s_axi_bready);
   COV_RD_CLR: cover property (status_change_pending ##1 rd_status ##1 !status_change_pending);
   COV_BUSOFF: cover property (evt.busoff && evt.recessive_run11);
endmodule // ccsp_ctrl_status

// ### testbench/ccsp_engine_model.sv
// Purpose: protocol engine stand-in that turns bench commands into events
// Assumes: one command at a time, go is a single-cycle pulse
// Notes: behavioural; no bit stream, only the outcome of each frame
`timescale 1ns/1ps
module ccsp_engine_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic go,
   input wire logic [2:0] kind,
   input wire logic [7:0] arg,
   output ccsp_pkg::ccsp_evt_s evt
);
   import ccsp_pkg::*;
   // kind: 0 error, 1 tx done, 2 rx done, 3 recessive run, 4 busoff, 5 tx count, 6 rx count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt <= '0;
      end else begin
         evt.err_valid <= go && kind == 3'h0;
         evt.err_code <= ccsp_lec_e'(arg[2:0]);
         evt.tx_ok <= go && kind == 3'h1;
         evt.rx_ok <= go && kind == 3'h2;
         // a recessive run only means recovery progress while busoff is held
         evt.recessive_run11 <= go && kind == 3'h3 && evt.busoff;
         if (go && kind == 3'h4) evt.busoff <= arg[0];
         if (go && kind == 3'h5) evt.tx_err_cnt <= arg;
         if (go && kind == 3'h6) evt.rx_err_cnt <= arg;
      end
   end
endmodule // ccsp_engine_model

// ### testbench/ccsp_ctrl_status_bench.sv
// Purpose: self-checking bench for the can control/status partition
// Assumes: axi4-lite master tasks, engine events from the partner model
// Notes: seed fixed, so every run repeats exactly
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module ccsp_ctrl_status_bench;
   import ccsp_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, pend;
   logic [1:0] bresp, rresp, rs;
   ccsp_evt_s evt;
   ccsp_ctl_s ctl;
   logic go = 1'b0;
   logic [2:0] kind = 3'h0;
   logic [7:0] arg = 8'h00, ctrl_m = 8'h01, tc = 8'h00, rcn = 8'h00;
   logic [2:0] lec_m = 3'h0;
   logic tx_m = 1'b0, rx_m = 1'b0, ew_m = 1'b0, bo_m = 1'b0;
   logic [31:0] seed = 32'h00010F7E;
   int error_cnt = 0;
   int n_compared = 0;
   logic [2:0] wk [5] = '{3'h5, 3'h5, 3'h5, 3'h6, 3'h6};
   logic [7:0] wv [5] = '{8'h5F, 8'h60, 8'h00, 8'h60, 8'h5F};

   ccsp_ctrl_status DUT (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt),
      .ctl(ctl), .status_change_pending(pend)
   );
   ccsp_engine_model engine (
      .aclk(aclk), .aresetn(aresetn), .go(go), .kind(kind), .arg(arg), .evt(evt)
   );

   initial begin
      forever #50 aclk = ~aclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [2:0] nxt_lec(input logic [2:0] k, input logic [2:0] c);
      if (k == 3'h0 && c != 3'h7) return c;
      if (k == 3'h1 || k == 3'h2) return 3'h0;
      if (k == 3'h3 && bo_m) return 3'h5;
      return lec_m;
   endfunction

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // each bus task ends one edge after the answer, so no signal is driven twice at an edge
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [3:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic ev(input logic [2:0] k, input logic [7:0] v);
      go <= 1'b1;
      kind <= k;
      arg <= v;
      @(posedge aclk);
      go <= 1'b0;
      repeat (3) @(posedge aclk);
      lec_m = nxt_lec(k, v[2:0]);
      if (k == 3'h1) tx_m = 1'b1;
      if (k == 3'h2) rx_m = 1'b1;
      if (k == 3'h4) bo_m = v[0];
      if (k == 3'h4 && v[0]) ctrl_m[CCSP_B_INIT] = 1'b1;
      if (k == 3'h5) tc = v;
      if (k == 3'h6) rcn = v;
      ew_m = (tc >= 8'(CCSP_WARN_LIMIT)) || (rcn >= 8'(CCSP_WARN_LIMIT));
   endtask

   task automatic wrc(input logic [7:0] c);
      ctrl_m = c & 8'h7F;
      axi_wr(CCSP_OFF_CTRL_STAT, {24'h000000, ctrl_m}, 4'h1);
      `CHK("bresp", CCSP_RESP_OKAY, rs)
   endtask

   task automatic wrs(input logic [7:0] d);
      axi_wr(CCSP_OFF_CTRL_STAT, {16'h0000, d, 8'h00}, 4'h2);
      lec_m = d[2:0];
      tx_m = tx_m & d[3];
      rx_m = rx_m & d[4];
   endtask

   task automatic chk_stat(input string nm);
      axi_rd(CCSP_OFF_CTRL_STAT);
      `CHK(nm, {16'h0000, bo_m, ew_m, 1'b0, rx_m, tx_m, lec_m, ctrl_m}, rd)
      `CHK("rresp", CCSP_RESP_OKAY, rs)
      `CHK("ctl", ctrl_m & 8'h83, {ctl.test_mode_bit, 5'h00, ctl.irq_en, ctl.init})
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      print_verdict();
   end

   initial begin
      logic [31:0] r;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk_stat("reset");
      wrc(8'h00);
      axi_wr(CCSP_OFF_BIT_TIMING, 32'h0000A5C3, 4'h3);
      `CHK("bt locked", 16'h0000, ctl.bit_timing)
      wrc(8'h40);
      axi_wr(CCSP_OFF_BIT_TIMING, 32'h0000A5C3, 4'h3);
      axi_rd(CCSP_OFF_BIT_TIMING);
      `CHK("bt open", 32'h0000A5C3, rd)
      `CHK("bt ctl", 16'hA5C3, ctl.bit_timing)
      wrc(8'h00);
      axi_rd(CCSP_OFF_BIT_TIMING);
      `CHK("bt hidden", 32'h00000000, rd)
      $display("test gate done");
      for (int c = 0; c < 8; c++) begin
         ev(3'h0, 8'(c));
         chk_stat("lec code");
      end
      wrs(8'h07);
      chk_stat("lec seven");
      ev(3'h0, 8'h07);
      chk_stat("lec kept");
      $display("test codes done");
      // mixes software clears with events so sticky flags meet both
      for (int i = 0; i < 40; i++) begin
         r = xs();
         if (r[3:0] < 4'h3) wrs({3'h0, r[9:8], r[6:4]});
         else ev(3'(r[1:0]), {5'h00, r[6:4]});
         chk_stat("random");
      end
      $display("test random done");
      for (int i = 0; i < 5; i++) begin
         ev(wk[i], wv[i]);
         chk_stat("warn");
      end
      $display("test warn done");
      ev(3'h4, 8'h01);
      chk_stat("busoff");
      wrs(8'h00);
      ev(3'h3, 8'h00);
      chk_stat("run11");
      wrc(8'h00);
      ev(3'h4, 8'h00);
      chk_stat("busoff off");
      $display("test busoff done");
      wrc(8'h06);
      axi_rd(CCSP_OFF_CTRL_STAT);
      `CHK("pend idle", 1'b0, pend)
      ev(3'h2, 8'h00);
      `CHK("pend set", 1'b1, pend)
      wrs(8'h00);
      `CHK("pend wr", 1'b1, pend)
      axi_rd(CCSP_OFF_CTRL_ONLY);
      `CHK("ctrl only", {24'h000000, ctrl_m}, rd)
      `CHK("pend low rd", 1'b1, pend)
      axi_rd(CCSP_OFF_CTRL_STAT);
      `CHK("pend clr", 1'b0, pend)
      wrs(8'h07);
      `CHK("pend no set", 1'b0, pend)
      // error enable without status enable: a warning edge must raise the pending change
      wrc(8'h0A);
      ev(3'h5, 8'h60);
      `CHK("pend warn", 1'b1, pend)
      chk_stat("warn pend");
      `CHK("pend warn clr", 1'b0, pend)
      $display("test pending done");
      axi_wr(4'hC, 32'hFFFFFFFF, 4'hF);
      `CHK("wr resp", CCSP_RESP_SLVERR, rs)
      axi_rd(4'hC);
      `CHK("rd resp", CCSP_RESP_SLVERR, rs)
      `CHK("rd data", 32'h00000000, rd)
      chk_stat("unmapped");
      $display("test unmapped done");
      print_verdict();
   end
endmodule // ccsp_ctrl_status_bench
